/* File: rtl/dsr_pkg.sv */
package dsr_pkg;
  // oscillator sources feeding the cpu clock before sleep
  typedef enum logic [1:0] {CLK_HOCO, CLK_X1, CLK_EXT, CLK_SUB} cpu_clk_src_t;
  // sequencer states
  typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_SLEEP, ST_WAKE, ST_VECTOR}
    seq_state_t;
  // timer a counting sources
  typedef enum logic [1:0] {TA_SRC_MAIN, TA_SRC_SUB, TA_SRC_LSOSC, TA_SRC_EVT}
    ta_src_t;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_MIN_US = 20;
  localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int EXT_RST_MIN_US = 10;
  localparam int EXT_RST_MIN_CYC = EXT_RST_MIN_US * CLK_MHZ;
  localparam int ISR_LAT_CYC = 14;
  localparam int RST_PROC_CYC = 64;
  localparam int CNT_W = 16;
  localparam int NUM_IRQ = 32;
  localparam int NUM_RST_SRC = 8;
  localparam logic [31:0] START_ADDR_RST = 32'h0000_0000;
  // reset source indices inside the cause vector
  localparam int RS_EXT = 0;
  localparam int RS_WDT = 1;
  localparam int RS_POR = 2;
  localparam int RS_LVD = 3;
  localparam int RS_SOFT = 4;
  localparam int RS_PAR = 5;
  localparam int RS_ILL = 6;
  localparam int RS_OSC = 7;
endpackage : dsr_pkg

/* File: rtl/dsr_wake_if.sv */
`timescale 1ns/1ps
interface dsr_wake_if;
  logic start;
  logic [dsr_pkg::CNT_W-1:0] wait_cyc;
  logic done;
  modport ctl (output start, output wait_cyc, input done);
  modport tmr (input start, input wait_cyc, output done);
endinterface : dsr_wake_if

/* File: rtl/dsr_wake_timer.sv */
`timescale 1ns/1ps
module dsr_wake_timer
  import dsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  dsr_wake_if.tmr wk
);
  logic [CNT_W-1:0] cnt_ff; // remaining settle cycles
  logic busy_ff; // count in progress
  logic done_ff; // one-cycle completion pulse
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_busy;
  logic nxt_done;
  wire last = busy_ff && (cnt_ff <= CNT_W'(1));
  // start loads the count; done pulses when it runs out
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (wk.start)
    begin
      nxt_cnt = wk.wait_cyc;
      nxt_busy = 1'b1;
    end
    else if (last)
    begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
    end
    else if (busy_ff)
      nxt_cnt = cnt_ff - CNT_W'(1);
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end
  assign wk.done = done_ff;
endmodule : dsr_wake_timer

/* File: rtl/deep_sleep_and_reset_control.sv */
// Functional notes
// - select bit set plus wait enters deep sleep; refused when running off the subclock
// - sleep keeps registers, ram, peripherals, io state
// - pending unmasked irq at wait wakes at once
// - sleep gates cpu clock, stops main oscillators
// - low speed osc runs per select/watchdog bits
// - timer a runs only in allowed modes
// - clock output runs on subclock, low-power bit 0
// - comparator runs only without digital filter
// - only spi and uart channels run, wake
// - i2c slave address match wakes device
// - transfer controller accepts triggers in sleep
// - wake, settle, vector or next instruction
// - release time at least 20us or settling
// - isr starts 14 clocks after irq valid
// - any reset ends sleep, restarts at vector
// - reset from pin, watchdog, por, lvd, parity...
// - system reset request bit gives internal reset
// - after reset run from program start address
// - reset stops oscillators, ignores ext clocks
// - reset port states: pullup pin, low output pin
`timescale 1ns/1ps
module deep_sleep_and_reset_control
  import dsr_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic i_deep_sleep_select,
  input wire logic i_wfi,
  input wire logic [NUM_IRQ-1:0] i_irq_req,
  input wire logic [NUM_IRQ-1:0] i_irq_mask,
  input wire logic i_irq_accept_en,
  input wire logic [1:0] i_cpu_clk_src,
  input wire logic i_pll_used,
  input wire logic [CNT_W-1:0] i_osc_settle_select,
  input wire logic [CNT_W-1:0] i_pll_lock_cyc,
  input wire logic i_subclock_lowspeed_select,
  input wire logic i_wdt_enable_option,
  input wire logic i_wdt_standby_run,
  input wire logic i_subclock_low_power,
  input wire logic i_sub_osc_on,
  input wire logic [1:0] i_timer_a_src,
  input wire logic i_timer_a_filter_en,
  input wire logic i_clkout_sub_src,
  input wire logic i_cmp_filter_en,
  input wire logic i_simple_spi_wake,
  input wire logic i_async_serial_wake,
  input wire logic i_i2c_addr_match,
  input wire logic i_dma_trigger,
  input wire logic i_external_reset_pin_n,
  input wire logic i_wdt_runaway,
  input wire logic i_por_det,
  input wire logic i_lvd_det,
  input wire logic i_system_reset_request,
  input wire logic i_ram_parity_err,
  input wire logic i_illegal_access,
  input wire logic i_osc_stop_det,
  output logic O_CPU_CLK_EN,
  output logic O_HIGH_SPEED_INTERNAL_OSC_EN,
  output logic O_CRYSTAL_MAIN_CLOCK_EN,
  output logic O_EXTERNAL_MAIN_CLOCK_EN,
  output logic O_CRYSTAL_SUB_CLOCK_EN,
  output logic O_EXTERNAL_SUB_CLOCK_EN,
  output logic O_LOW_SPEED_INTERNAL_OSC_EN,
  output logic O_RETAIN,
  output logic O_DEEP_SLEEP,
  output logic O_TIMER_A_RUN_EN,
  output logic O_CLKOUT_RUN_EN,
  output logic O_CMP_RUN_EN,
  output logic O_SERIAL_OTHER_EN,
  output logic O_DMA_TRIGGER,
  output logic O_IRQ_VECTOR,
  output logic O_RESUME_NEXT,
  output logic O_SYS_RESET,
  output logic [31:0] O_START_ADDR,
  output logic O_START_VALID,
  output logic [NUM_RST_SRC-1:0] O_RESET_CAUSE,
  output logic O_PULLED_UP_PORT_PIN_O,
  output logic O_PULLED_UP_PORT_PIN_OE,
  output logic O_RESET_OUTPUT_PORT_PIN_O,
  output logic O_RESET_OUTPUT_PORT_PIN_OE
);
  // pin synchronisers for the external reset pin
  logic rst_pin_s1_ff; // first stage, read by second only
  logic rst_pin_s2_ff; // synced pin level, active low
  logic [CNT_W-1:0] pin_lo_cnt_ff; // low-time counter for the pin
  logic ext_rst_ff; // external reset qualified by min low time
  logic [NUM_RST_SRC-1:0] cause_ff; // latched source of last reset
  logic [CNT_W-1:0] proc_cnt_ff; // reset processing counter
  logic [3:0] lat_cnt_ff; // interrupt latency counter
  logic vec_ff; // wake goes to isr versus next instruction
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [CNT_W-1:0] nxt_proc_cnt;
  logic [3:0] nxt_lat_cnt;
  // registered outputs
  logic cpu_clk_en_ff, hoco_en_ff, x1_en_ff, ext_en_ff;
  logic xt_en_ff, exs_en_ff, lsosc_en_ff, sleep_ff;
  logic ta_en_ff, clko_en_ff, cmp_en_ff, ser_oth_en_ff, dma_ff;
  logic vector_ff, resume_ff, sys_rst_ff, start_valid_ff;
  logic pu_o_ff, pu_oe_ff;
  dsr_wake_if wk ();
  // settle-time timer lives in its own module
  dsr_wake_timer u_wake_timer (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .wk(wk)
  );
  // decode the pending unmasked interrupt and wake sources
  wire irq_pending = |(i_irq_req & ~i_irq_mask);
  wire wake_src = irq_pending
    | i_simple_spi_wake | i_async_serial_wake
    | i_i2c_addr_match;
  wire ext_pin_low = ~rst_pin_s2_ff;
  wire [NUM_RST_SRC-1:0] rst_src = {
    i_osc_stop_det, i_illegal_access, i_ram_parity_err,
    i_system_reset_request,
    i_lvd_det, i_por_det, i_wdt_runaway, ext_rst_ff};
  wire any_rst = |rst_src;
  // sleep is refused when running off the subclock; firmware owes us that
  wire main_clk = (cpu_clk_src_t'(i_cpu_clk_src) != CLK_SUB);
  wire sleep_req = i_wfi & i_deep_sleep_select & main_clk;
  wire in_sleep = (state_ff == ST_SLEEP);
  // release time: 20us floor, crystal may take longer, plus pll lock
  wire [CNT_W-1:0] min_wait = CNT_W'(WAKE_MIN_CYC);
  wire x1_src = (cpu_clk_src_t'(i_cpu_clk_src) == CLK_X1);
  wire [CNT_W-1:0] x1_wait = (i_osc_settle_select > min_wait) ?
    i_osc_settle_select : min_wait;
  wire [CNT_W-1:0] base_wait = x1_src ? x1_wait : min_wait;
  wire [CNT_W-1:0] pll_add = i_pll_used ? i_pll_lock_cyc : '0;
  assign wk.wait_cyc = base_wait + pll_add;
  // settle count starts on the edge that leaves sleep; reset wins
  assign wk.start = in_sleep && wake_src && !any_rst;
  // peripheral run permissions while asleep
  wire lsosc_run = i_subclock_lowspeed_select |
    (i_wdt_enable_option & i_wdt_standby_run);
  wire ta_ok = (ta_src_t'(i_timer_a_src) == TA_SRC_EVT &&
    !i_timer_a_filter_en) ||
    (ta_src_t'(i_timer_a_src) == TA_SRC_SUB && !i_subclock_low_power) ||
    (ta_src_t'(i_timer_a_src) == TA_SRC_LSOSC);
  wire clko_ok = i_clkout_sub_src & ~i_subclock_low_power;
  wire cmp_ok = ~i_cmp_filter_en;
  // two-flop synchroniser for the reset pin
  always_ff @(posedge I_MCLK)
  begin
    rst_pin_s1_ff <= i_external_reset_pin_n;
    rst_pin_s2_ff <= rst_pin_s1_ff;
  end
  // pin must stay low the minimum time before it counts as a reset
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET || !ext_pin_low)
      pin_lo_cnt_ff <= '0;
    else if (pin_lo_cnt_ff != CNT_W'(EXT_RST_MIN_CYC))
      pin_lo_cnt_ff <= pin_lo_cnt_ff + CNT_W'(1);
  end
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      ext_rst_ff <= 1'b0;
    else
      ext_rst_ff <= ext_pin_low &&
        (pin_lo_cnt_ff == CNT_W'(EXT_RST_MIN_CYC));
  end
  // sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_proc_cnt = proc_cnt_ff;
    nxt_lat_cnt = lat_cnt_ff;
    case (state_ff)
      ST_RESET:
      begin
        // hold while any source stands, then run the processing delay
        if (any_rst)
          nxt_proc_cnt = CNT_W'(RST_PROC_CYC);
        else if (proc_cnt_ff == '0)
          nxt_state = ST_RUN;
        else
          nxt_proc_cnt = proc_cnt_ff - CNT_W'(1);
      end
      ST_RUN:
      begin
        if (sleep_req)
          nxt_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wake_src)
          nxt_state = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (wk.done)
        begin
          nxt_state = ST_VECTOR;
          nxt_lat_cnt = 4'(ISR_LAT_CYC);
        end
      end
      ST_VECTOR:
      begin
        if (lat_cnt_ff <= 4'(1))
          nxt_state = ST_RUN;
        else
          nxt_lat_cnt = lat_cnt_ff - 4'(1);
      end
      default:
        nxt_state = ST_RESET;
    endcase
    if (any_rst)
    begin
      nxt_state = ST_RESET;
      nxt_proc_cnt = CNT_W'(RST_PROC_CYC);
    end
  end
  // sequencer registers
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      state_ff <= ST_RESET;
      proc_cnt_ff <= CNT_W'(RST_PROC_CYC);
      lat_cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      proc_cnt_ff <= nxt_proc_cnt;
      lat_cnt_ff <= nxt_lat_cnt;
    end
  end
  // remember the reset cause and the interrupt acceptance at wake
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      cause_ff <= '0;
      vec_ff <= 1'b0;
    end
    else
    begin
      if (any_rst)
        cause_ff <= rst_src;
      if (in_sleep && wake_src)
        vec_ff <= i_irq_accept_en & irq_pending;
    end
  end
  // clock gating and run permissions
  wire in_rst = (nxt_state == ST_RESET);
  wire asleep = (nxt_state == ST_SLEEP);
  wire main_run = ~in_rst & ~asleep;
  wire src_hoco = (cpu_clk_src_t'(i_cpu_clk_src) == CLK_HOCO);
  wire src_ext = (cpu_clk_src_t'(i_cpu_clk_src) == CLK_EXT);
  wire pu_drive = ~(rst_src[RS_EXT] | rst_src[RS_POR]);
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      cpu_clk_en_ff <= 1'b0;
      hoco_en_ff <= 1'b0;
      x1_en_ff <= 1'b0;
      ext_en_ff <= 1'b0;
      xt_en_ff <= 1'b0;
      exs_en_ff <= 1'b0;
      lsosc_en_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else
    begin
      cpu_clk_en_ff <= (nxt_state == ST_RUN) ||
        (nxt_state == ST_VECTOR);
      hoco_en_ff <= main_run && (src_hoco || state_ff == ST_RESET);
      x1_en_ff <= main_run && x1_src;
      ext_en_ff <= main_run && src_ext;
      // subclock keeps its prior state in sleep
      xt_en_ff <= ~in_rst & (asleep ? xt_en_ff : i_sub_osc_on);
      exs_en_ff <= ~in_rst & (asleep ? exs_en_ff : i_sub_osc_on);
      lsosc_en_ff <= ~in_rst & (~asleep | lsosc_run);
      sleep_ff <= asleep;
    end
  end
  // peripheral enables and event outputs
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      ta_en_ff <= 1'b0;
      clko_en_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
      ser_oth_en_ff <= 1'b0;
      dma_ff <= 1'b0;
      vector_ff <= 1'b0;
      resume_ff <= 1'b0;
      sys_rst_ff <= 1'b1;
      start_valid_ff <= 1'b0;
      pu_o_ff <= 1'b0;
      pu_oe_ff <= 1'b0;
    end
    else
    begin
      ta_en_ff <= main_run | (asleep & ta_ok);
      clko_en_ff <= main_run | (asleep & clko_ok);
      cmp_en_ff <= main_run | (asleep & cmp_ok);
      ser_oth_en_ff <= main_run;
      dma_ff <= ~in_rst & i_dma_trigger;
      vector_ff <= (state_ff == ST_VECTOR) && (nxt_state == ST_RUN) &&
        vec_ff;
      resume_ff <= (state_ff == ST_VECTOR) && (nxt_state == ST_RUN) &&
        !vec_ff;
      sys_rst_ff <= in_rst;
      start_valid_ff <= (state_ff == ST_RESET) &&
        (nxt_state == ST_RUN);
      if (any_rst)
      begin
        pu_o_ff <= pu_drive;
        pu_oe_ff <= pu_drive;
      end
    end
  end
  assign O_CPU_CLK_EN = cpu_clk_en_ff;
  assign O_HIGH_SPEED_INTERNAL_OSC_EN = hoco_en_ff;
  assign O_CRYSTAL_MAIN_CLOCK_EN = x1_en_ff;
  assign O_EXTERNAL_MAIN_CLOCK_EN = ext_en_ff;
  assign O_CRYSTAL_SUB_CLOCK_EN = xt_en_ff;
  assign O_EXTERNAL_SUB_CLOCK_EN = exs_en_ff;
  assign O_LOW_SPEED_INTERNAL_OSC_EN = lsosc_en_ff;
  assign O_RETAIN = sleep_ff; // state held, not reset, while asleep
  assign O_DEEP_SLEEP = sleep_ff;
  assign O_TIMER_A_RUN_EN = ta_en_ff;
  assign O_CLKOUT_RUN_EN = clko_en_ff;
  assign O_CMP_RUN_EN = cmp_en_ff;
  assign O_SERIAL_OTHER_EN = ser_oth_en_ff;
  assign O_DMA_TRIGGER = dma_ff;
  assign O_IRQ_VECTOR = vector_ff;
  assign O_RESUME_NEXT = resume_ff;
  assign O_SYS_RESET = sys_rst_ff;
  assign O_START_ADDR = START_ADDR_RST;
  assign O_START_VALID = start_valid_ff;
  assign O_RESET_CAUSE = cause_ff;
  assign O_PULLED_UP_PORT_PIN_O = pu_o_ff;
  assign O_PULLED_UP_PORT_PIN_OE = pu_oe_ff;
  // reset output pin always drives low from reset onward
  assign O_RESET_OUTPUT_PORT_PIN_O = 1'b0;
  assign O_RESET_OUTPUT_PORT_PIN_OE = 1'b1;
endmodule : deep_sleep_and_reset_control

/* File: verif/dsr_core_model.sv */
`timescale 1ns/1ps
module dsr_core_model
  import dsr_pkg::*;
(
  input wire logic i_clk,
  output logic o_wfi,
  output logic [NUM_IRQ-1:0] o_irq,
  output logic o_pin_n
);
  // idle core: no wait, no request, reset pin released
  initial
  begin
    o_wfi = 1'h0;
    o_irq = '0;
    o_pin_n = 1'h1;
  end
  // one-cycle wait; t_refuse also asks for sleep from the subclock
  task automatic do_wfi();
    o_wfi = 1'h1;
    @(posedge i_clk);
    #1 o_wfi = 1'h0;
  endtask : do_wfi
  // one request line at a time, negative index drops all
  task automatic set_irq(input int idx);
    o_irq = (idx < 0) ? '0 : NUM_IRQ'(1) << idx;
  endtask : set_irq
  // pin held low for n cycles by the outside agent
  task automatic hold_low(input int n);
    o_pin_n = 1'h0;
    repeat (n) @(posedge i_clk);
    #1 o_pin_n = 1'h1;
  endtask : hold_low
endmodule : dsr_core_model

/* File: verif/deep_sleep_and_reset_control_assertions.sv */
`timescale 1ns/1ps
module dsr_checker
  import dsr_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic i_deep_sleep_select,
  input wire logic i_wfi,
  input wire logic [NUM_IRQ-1:0] i_irq_req,
  input wire logic [NUM_IRQ-1:0] i_irq_mask,
  input wire logic [1:0] i_cpu_clk_src,
  input wire logic i_subclock_lowspeed_select,
  input wire logic i_wdt_enable_option,
  input wire logic i_wdt_standby_run,
  input wire logic i_subclock_low_power,
  input wire logic [1:0] i_timer_a_src,
  input wire logic i_timer_a_filter_en,
  input wire logic O_CPU_CLK_EN,
  input wire logic O_HIGH_SPEED_INTERNAL_OSC_EN,
  input wire logic O_CRYSTAL_MAIN_CLOCK_EN,
  input wire logic O_EXTERNAL_MAIN_CLOCK_EN,
  input wire logic O_LOW_SPEED_INTERNAL_OSC_EN,
  input wire logic O_RETAIN,
  input wire logic O_DEEP_SLEEP,
  input wire logic O_TIMER_A_RUN_EN,
  input wire logic O_SERIAL_OTHER_EN,
  input wire logic O_SYS_RESET
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);
  // allow one or two cycles of answer latency after the wait
  sleep_entry_a: assert property (
    $rose(O_DEEP_SLEEP) |-> $past(i_wfi && i_deep_sleep_select)
      || $past(i_wfi && i_deep_sleep_select, 2))
    else $error("sleep without wait request");
  subclk_refuse_a: assert property (
    !O_DEEP_SLEEP && i_wfi && (i_cpu_clk_src == 2'h3
      || !i_deep_sleep_select) |=> !O_DEEP_SLEEP [*2])
    else $error("sleep taken when refused");
  state_retain_a: assert property (
    O_DEEP_SLEEP |-> O_RETAIN)
    else $error("retain low in sleep");
  // skip the entry cycle, the enables are registered
  main_osc_a: assert property (
    O_DEEP_SLEEP [*2] |-> !(O_CPU_CLK_EN || O_CRYSTAL_MAIN_CLOCK_EN
      || O_HIGH_SPEED_INTERNAL_OSC_EN || O_EXTERNAL_MAIN_CLOCK_EN))
    else $error("main clock left running in sleep");
  lsosc_keep_a: assert property (
    O_DEEP_SLEEP [*3] |-> O_LOW_SPEED_INTERNAL_OSC_EN ==
      (i_subclock_lowspeed_select
      || (i_wdt_enable_option && i_wdt_standby_run)))
    else $error("low speed osc enable wrong");
  timer_perm_a: assert property (
    O_DEEP_SLEEP [*3] |-> O_TIMER_A_RUN_EN == (i_timer_a_src == 2'h2
      || (i_timer_a_src == 2'h3 && !i_timer_a_filter_en)
      || (i_timer_a_src == 2'h1 && !i_subclock_low_power)))
    else $error("timer a permission wrong");
  serial_stop_a: assert property (
    O_DEEP_SLEEP [*2] |-> !O_SERIAL_OTHER_EN)
    else $error("other serial channels run");
  irq_wake_a: assert property (
    O_DEEP_SLEEP && |(i_irq_req & ~i_irq_mask) |=> !O_DEEP_SLEEP)
    else $error("unmasked request did not wake");
  rst_osc_stop_a: assert property (
    O_SYS_RESET [*2] |-> !(O_HIGH_SPEED_INTERNAL_OSC_EN
      || O_CRYSTAL_MAIN_CLOCK_EN || O_EXTERNAL_MAIN_CLOCK_EN
      || O_LOW_SPEED_INTERNAL_OSC_EN))
    else $error("oscillator running in reset");
endmodule : dsr_checker

bind deep_sleep_and_reset_control dsr_checker u_dsr_checker (.*);

/* File: verif/tb_deep_sleep_and_reset_control.sv */
`timescale 1ns/1ps
module tb_deep_sleep_and_reset_control;
  import dsr_pkg::*;
  logic I_MCLK = 1'h0;
  logic I_RESET = 1'h1;
  logic i_deep_sleep_select = 1'h0;
  logic i_irq_accept_en = 1'h0;
  logic i_pll_used = 1'h0;
  logic i_sub_osc_on = 1'h1;
  logic [NUM_IRQ-1:0] i_irq_mask = ~(NUM_IRQ'(1) << 5); // only line 5 open
  logic [1:0] i_cpu_clk_src = '0, i_timer_a_src = '0;
  logic [CNT_W-1:0] i_osc_settle_select = '0, i_pll_lock_cyc = 16'h0010;
  logic [7:0] cfg = '0; // sleep configuration bits
  logic [7:0] rsrc = '0; // internal reset sources by cause index
  logic i_simple_spi_wake = 1'h0, i_async_serial_wake = 1'h0;
  logic i_i2c_addr_match = 1'h0, i_dma_trigger = 1'h0;
  wire i_wfi, i_external_reset_pin_n;
  wire [NUM_IRQ-1:0] i_irq_req;
  wire i_subclock_lowspeed_select = cfg[0];
  wire i_wdt_enable_option = cfg[1];
  wire i_wdt_standby_run = cfg[2];
  wire i_subclock_low_power = cfg[3];
  wire i_timer_a_filter_en = cfg[4];
  wire i_clkout_sub_src = cfg[5];
  wire i_cmp_filter_en = cfg[6];
  wire i_wdt_runaway = rsrc[RS_WDT];
  wire i_por_det = rsrc[RS_POR];
  wire i_lvd_det = rsrc[RS_LVD];
  wire i_system_reset_request = rsrc[RS_SOFT];
  wire i_ram_parity_err = rsrc[RS_PAR];
  wire i_illegal_access = rsrc[RS_ILL];
  wire i_osc_stop_det = rsrc[RS_OSC];
  logic O_CPU_CLK_EN, O_HIGH_SPEED_INTERNAL_OSC_EN, O_RETAIN;
  logic O_CRYSTAL_MAIN_CLOCK_EN, O_EXTERNAL_MAIN_CLOCK_EN, O_DEEP_SLEEP;
  logic O_CRYSTAL_SUB_CLOCK_EN, O_EXTERNAL_SUB_CLOCK_EN, O_SYS_RESET;
  logic O_LOW_SPEED_INTERNAL_OSC_EN, O_TIMER_A_RUN_EN, O_CLKOUT_RUN_EN;
  logic O_CMP_RUN_EN, O_SERIAL_OTHER_EN, O_DMA_TRIGGER, O_IRQ_VECTOR;
  logic O_RESUME_NEXT, O_START_VALID, O_PULLED_UP_PORT_PIN_O;
  logic O_PULLED_UP_PORT_PIN_OE, O_RESET_OUTPUT_PORT_PIN_O;
  logic O_RESET_OUTPUT_PORT_PIN_OE;
  logic [31:0] O_START_ADDR;
  logic [NUM_RST_SRC-1:0] O_RESET_CAUSE;
  int err_count = 0, tests_run = 0;
  int n;

  deep_sleep_and_reset_control u_deep_sleep_and_reset_control (.*);
  dsr_core_model u_dsr_core_model (.i_clk(I_MCLK), .o_wfi(i_wfi),
    .o_irq(i_irq_req), .o_pin_n(i_external_reset_pin_n));

  always #5 I_MCLK = ~I_MCLK;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge I_MCLK);
    #1;
  endtask : tick

  // bounded wait: 0 start, 1 vector or resume, 2 reset, else asleep
  task automatic wait_on(input int sel, input int lim, output int took);
    logic hit;
    took = 0;
    hit = 1'h0;
    while (!hit)
    begin
      tick(1);
      took++;
      case (sel)
        0: hit = (O_START_VALID === 1'h1);
        1: hit = ((O_IRQ_VECTOR | O_RESUME_NEXT) === 1'h1);
        2: hit = (O_SYS_RESET === 1'h1);
        default: hit = (O_DEEP_SLEEP === 1'h1);
      endcase
      if (!hit && took >= lim)
      begin
        err_count++;
        $display("[ERR] %0t wait %0d ran out", $time, sel);
        report_and_stop();
      end
    end
  endtask : wait_on

  // masked request keeps sleep, unmasked one wakes after release time
  task automatic t_irq_wake(input logic [1:0] src, input logic acc);
    i_cpu_clk_src = src;
    i_irq_accept_en = acc;
    i_deep_sleep_select = 1'h1;
    i_osc_settle_select = (src == 2'h1) ? 16'h09c4 : '0;
    i_pll_used = (src == 2'h1);
    u_dsr_core_model.do_wfi();
    wait_on(3, 3, n);
    u_dsr_core_model.set_irq(6);
    tick(4);
    chk(O_DEEP_SLEEP, 1);
    u_dsr_core_model.set_irq(5);
    wait_on(1, 6000, n);
    u_dsr_core_model.set_irq(-1);
    chk(O_IRQ_VECTOR, acc);
    chk(O_RESUME_NEXT, !acc);
    chk(n >= ((src == 2'h1) ? 2500 + 16 : WAKE_MIN_CYC), 1);
    chk(n <= ((src == 2'h1) ? 2516 : WAKE_MIN_CYC) + 18, 1);
    chk(O_CPU_CLK_EN, 1);
    $display("irq wake src %0d done", src);
  endtask : t_irq_wake

  // request already pending when the wait executes
  task automatic t_pending();
    u_dsr_core_model.set_irq(5);
    u_dsr_core_model.do_wfi();
    wait_on(1, 6000, n);
    u_dsr_core_model.set_irq(-1);
    chk(O_IRQ_VECTOR, 1);
    $display("pending wake done");
  endtask : t_pending

  // subclock or cleared select bit must not sleep
  task automatic t_refuse();
    i_cpu_clk_src = 2'h3;
    u_dsr_core_model.do_wfi();
    tick(3);
    chk(O_DEEP_SLEEP, 0);
    i_cpu_clk_src = 2'h0;
    i_deep_sleep_select = 1'h0;
    u_dsr_core_model.do_wfi();
    tick(3);
    chk(O_DEEP_SLEEP, 0);
    i_deep_sleep_select = 1'h1;
    $display("refuse done");
  endtask : t_refuse

  // permissions per configuration, dma passthrough, serial/i2c wake
  task automatic t_perm();
    for (int k = 0; k < 8; k++)
    begin
      cfg = 8'(k * 37);
      i_timer_a_src = k[1:0];
      u_dsr_core_model.do_wfi();
      wait_on(3, 3, n);
      tick(3);
      chk(O_CLKOUT_RUN_EN, cfg[5] & !cfg[3]);
      chk(O_CMP_RUN_EN, !cfg[6]);
      chk(O_RETAIN, 1);
      chk({O_CRYSTAL_SUB_CLOCK_EN, O_EXTERNAL_SUB_CLOCK_EN}, 3);
      i_dma_trigger = 1'h1;
      tick(1);
      i_dma_trigger = 1'h0;
      chk(O_DMA_TRIGGER, 1);
      i_simple_spi_wake = (k % 3 == 0);
      i_async_serial_wake = (k % 3 == 1);
      i_i2c_addr_match = (k % 3 == 2);
      wait_on(1, 6000, n);
      {i_simple_spi_wake, i_async_serial_wake, i_i2c_addr_match} = '0;
      chk(O_DEEP_SLEEP, 0);
    end
    $display("permissions done");
  endtask : t_perm

  // every internal source ends sleep, pin reset comes from run; cause, ports and start address after it
  task automatic t_resets();
    for (int i = 1; i < NUM_RST_SRC; i++)
    begin
      u_dsr_core_model.do_wfi();
      wait_on(3, 3, n);
      rsrc[i] = 1'h1;
      tick(2);
      rsrc = '0;
      wait_on(2, 4, n);
      chk(O_DEEP_SLEEP, 0);
      chk({O_CRYSTAL_SUB_CLOCK_EN, O_EXTERNAL_SUB_CLOCK_EN}, 0);
      chk({O_RESET_OUTPUT_PORT_PIN_O, O_RESET_OUTPUT_PORT_PIN_OE}, 1);
      wait_on(0, 200, n);
      chk(O_RESET_CAUSE[i], 1);
      chk(O_START_ADDR, START_ADDR_RST);
      chk({O_PULLED_UP_PORT_PIN_O, O_PULLED_UP_PORT_PIN_OE},
        (i == RS_POR) ? 0 : 3);
    end
    u_dsr_core_model.hold_low(100);
    tick(4);
    chk(O_SYS_RESET, 0);
    u_dsr_core_model.hold_low(EXT_RST_MIN_CYC + 20);
    chk(O_SYS_RESET, 1);
    wait_on(0, 200, n);
    chk(O_RESET_CAUSE[RS_EXT], 1);
    chk({O_PULLED_UP_PORT_PIN_O, O_PULLED_UP_PORT_PIN_OE}, 0);
    $display("resets done");
  endtask : t_resets

  // reset two cycles, then the scenarios in turn
  initial
  begin
    tick(2);
    I_RESET = 1'h0;
    wait_on(0, 100, n);
    chk(O_START_ADDR, START_ADDR_RST);
    for (int s = 0; s < 3; s++)
      t_irq_wake(2'(s), s != 1);
    t_pending();
    t_refuse();
    t_perm();
    t_resets();
    report_and_stop();
  end
endmodule : tb_deep_sleep_and_reset_control
